// ### core/hstr_readout.sv
module hstr_readout
    import hstr_pkg::*;
#(
    parameter logic [6:0]  DEV_ADDR    = 7'h30,
    parameter logic [7:0]  TRIM_OFFSET = 8'h00,
    parameter logic [7:0]  TRIM_GAIN   = 8'h00,
    parameter int          TEMP_REF    = 16384,
    parameter int          TC_COEF     = 0,
    parameter int          TC_SHIFT    = 8
)(
    input  wire logic                sys_clk_i,
    input  wire logic                rst_b_i,
    input  wire logic                scl_i,
    input  wire logic                sda_i,
    output logic                     sda_o,
    output logic                     sda_oe_b_o,
    input  wire logic                conv_done_i,
    input  wire logic [CODE_W-1:0]   field_code_i,
    input  wire logic [CODE_W-1:0]   temp_code_i
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic              scl_m;
        logic              scl_s;
        logic              scl_d;
        logic              sda_m;
        logic              sda_s;
        logic              sda_d;
        hstr_state_e       st;
        logic [3:0]        bitcnt;
        logic [7:0]        shift;
        logic              rw;
        logic              have_ptr;
        logic [7:0]        ptr;
        logic              sda_low;
        logic [SEL_W-1:0]  sel;
        logic [2:0]        bsz;
        logic [7:0]        otp_addr;
        logic [7:0]        otp_data;
        logic              otp_rd;
        logic [ACC_W-1:0]  acc;
        logic [4:0]        cnt;
        logic [CODE_W-1:0] field_res;
        logic [CODE_W-1:0] temp_res;
        logic              fresh;
    } hstr_state_s;

    hstr_state_s q_reg;
    hstr_state_s q_next;

    // trim memory, only the two trim bytes are populated here
    function automatic logic [7:0] otp_rom(input logic [7:0] a);
        case (a)
            OTP_OFFSET_ADDR: otp_rom = TRIM_OFFSET;
            OTP_GAIN_ADDR:   otp_rom = TRIM_GAIN;
            default:         otp_rom = 8'h00;
        endcase
    endfunction

    // ************************************************************
    // conversion datapath, register read mux and bus edge detect
    // ************************************************************
    logic              scl_rise;
    logic              scl_fall;
    logic              start_c;
    logic              stop_c;
    logic [CODE_W-1:0] data_sel;
    logic [4:0]        burst_last;
    logic              last_conv;
    logic [ACC_W-1:0]  acc_sum;
    logic [CODE_W-1:0] avg;
    logic signed [31:0] corr;
    logic signed [31:0] fsum;
    logic [CODE_W-1:0] fcomp;
    logic [7:0]        rdata;

    // averaged field compensated against the temperature sample of the burst's last conversion
    always_comb
    begin
        burst_last = 5'((5'h1 << q_reg.bsz) - 5'h1);
        last_conv  = conv_done_i && (q_reg.cnt >= burst_last);   // a burst shrunk mid-way still ends
        acc_sum    = q_reg.acc + ACC_W'(field_code_i);
        avg        = CODE_W'(acc_sum >> q_reg.bsz);
        corr       = ((signed'({17'h0, temp_code_i}) - TEMP_REF) * TC_COEF) >>> TC_SHIFT;
        fsum       = signed'({17'h0, avg}) + corr;
        if (fsum < 0)
            fcomp = '0;
        else if (fsum > signed'({17'h0, CODE_MAX}))
            fcomp = CODE_MAX;
        else
            fcomp = fsum[CODE_W-1:0];
        data_sel = (q_reg.sel == SEL_TEMP) ? q_reg.temp_res : q_reg.field_res;
        case (q_reg.ptr)
            ADDR_DATA_HIGH: rdata = {q_reg.fresh, data_sel[14:8]};
            ADDR_DATA_LOW:  rdata = data_sel[7:0];
            ADDR_SIG_SEL:   rdata = {5'h0, q_reg.sel};
            ADDR_BURST:     rdata = {5'h0, q_reg.bsz};
            ADDR_OTP_ADDR:  rdata = q_reg.otp_addr;
            ADDR_OTP_DATA:  rdata = q_reg.otp_data;
            ADDR_OTP_CTRL:  rdata = {6'h0, q_reg.otp_rd, q_reg.otp_rd};
            default:        rdata = 8'h00;
        endcase
        scl_rise = q_reg.scl_s && !q_reg.scl_d;
        scl_fall = !q_reg.scl_s && q_reg.scl_d;
        start_c  = q_reg.scl_s && q_reg.scl_d && q_reg.sda_d && !q_reg.sda_s;
        stop_c   = q_reg.scl_s && q_reg.scl_d && !q_reg.sda_d && q_reg.sda_s;
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        q_next = q_reg;
        // pins pass three flops; edge logic only reads the second and third
        q_next.scl_m = scl_i;
        q_next.scl_s = q_reg.scl_m;
        q_next.scl_d = q_reg.scl_s;
        q_next.sda_m = sda_i;
        q_next.sda_s = q_reg.sda_m;
        q_next.sda_d = q_reg.sda_s;

        // trim fetch completes one cycle after the request
        if (q_reg.otp_rd)
        begin
            q_next.otp_data = otp_rom(q_reg.otp_addr);
            q_next.otp_rd   = 1'b0;
        end

        // serial slave
        if (start_c)
        begin
            q_next.st       = ST_ADDR;
            q_next.bitcnt   = 4'h0;
            q_next.have_ptr = 1'b0;
            q_next.sda_low  = 1'b0;
        end
        else if (stop_c)
        begin
            q_next.st      = ST_IDLE;
            q_next.sda_low = 1'b0;
        end
        else
        begin
            case (q_reg.st)
                ST_ADDR, ST_WRITE:
                    if (scl_rise)
                    begin
                        q_next.shift  = {q_reg.shift[6:0], q_reg.sda_s};
                        q_next.bitcnt = q_reg.bitcnt + 4'h1;
                        if (q_reg.bitcnt == 4'h7)
                        begin
                            if (q_reg.st == ST_WRITE)
                                q_next.st = ST_ACK_W;
                            else if (q_reg.shift[6:0] == DEV_ADDR)
                            begin
                                q_next.st = ST_ACK_A;
                                q_next.rw = q_reg.sda_s;
                            end
                            else
                                q_next.st = ST_IDLE;
                        end
                    end
                ST_ACK_A:
                    if (scl_fall && !q_reg.sda_low)
                        q_next.sda_low = 1'b1;
                    else if (scl_fall)
                    begin
                        q_next.bitcnt = 4'h0;
                        if (q_reg.rw)
                        begin
                            q_next.st      = ST_READ;
                            q_next.shift   = rdata;
                            q_next.sda_low = !rdata[7];
                            q_next.ptr     = q_reg.ptr + 8'h1;
                            if (q_reg.ptr == ADDR_DATA_HIGH)
                                q_next.fresh = 1'b0;
                        end
                        else
                        begin
                            q_next.st      = ST_WRITE;
                            q_next.sda_low = 1'b0;
                        end
                    end
                ST_ACK_W:
                    if (scl_fall && !q_reg.sda_low)
                    begin
                        q_next.sda_low = 1'b1;
                        if (!q_reg.have_ptr)
                        begin
                            q_next.ptr      = q_reg.shift;
                            q_next.have_ptr = 1'b1;
                        end
                        else
                        begin
                            q_next.ptr = q_reg.ptr + 8'h1;
                            case (q_reg.ptr)
                                ADDR_SIG_SEL:  q_next.sel = q_reg.shift[SEL_W-1:0];
                                ADDR_BURST:
                                    q_next.bsz = (q_reg.shift[2:0] > BURST_LOG2_MAX) ?
                                                 BURST_LOG2_MAX : q_reg.shift[2:0];
                                ADDR_OTP_ADDR: q_next.otp_addr = q_reg.shift;
                                ADDR_OTP_CTRL:
                                    if (q_reg.shift[OTP_RD_EN_BIT])
                                        q_next.otp_rd = 1'b1;
                                default: ;
                            endcase
                        end
                    end
                    else if (scl_fall)
                    begin
                        q_next.sda_low = 1'b0;
                        q_next.bitcnt  = 4'h0;
                        q_next.st      = ST_WRITE;
                    end
                ST_READ:
                    if (scl_fall)
                    begin
                        q_next.bitcnt = q_reg.bitcnt + 4'h1;
                        q_next.shift  = {q_reg.shift[6:0], 1'b0};
                        q_next.sda_low = !q_reg.shift[6];
                        if (q_reg.bitcnt == 4'h7)
                        begin
                            q_next.sda_low = 1'b0;
                            q_next.bitcnt  = 4'h0;
                            q_next.st      = ST_ACK_R;
                        end
                    end
                ST_ACK_R:
                    // master ack on the rise, next byte launched on the fall
                    if (scl_rise)
                    begin
                        if (q_reg.sda_s)
                            q_next.st = ST_IDLE;
                        else
                            q_next.bitcnt = 4'h8;
                    end
                    else if (scl_fall && q_reg.bitcnt == 4'h8)
                    begin
                        q_next.st      = ST_READ;
                        q_next.bitcnt  = 4'h0;
                        q_next.shift   = rdata;
                        q_next.sda_low = !rdata[7];
                        q_next.ptr     = q_reg.ptr + 8'h1;
                        if (q_reg.ptr == ADDR_DATA_HIGH)
                            q_next.fresh = 1'b0;
                    end
                default: q_next.st = ST_IDLE;
            endcase
        end

        // conversions last, so a new result wins over a read clear
        if (conv_done_i)
        begin
            q_next.acc = acc_sum;
            q_next.cnt = q_reg.cnt + 5'h1;
            if (last_conv)
            begin
                q_next.field_res = fcomp;
                q_next.temp_res  = temp_code_i;
                q_next.fresh     = 1'b1;
                q_next.acc       = '0;
                q_next.cnt       = 5'h0;
            end
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
        begin
            q_reg       <= '0;
            q_reg.scl_m <= 1'b1;
            q_reg.scl_s <= 1'b1;
            q_reg.scl_d <= 1'b1;
            q_reg.sda_m <= 1'b1;
            q_reg.sda_s <= 1'b1;
            q_reg.sda_d <= 1'b1;
            q_reg.st    <= ST_IDLE;
            q_reg.sel   <= SEL_FIELD;
        end
        else
            q_reg <= q_next;
    end

    // open drain: only ever pulls low
    assign sda_o      = 1'b0;
    assign sda_oe_b_o = !q_reg.sda_low;

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_otp_req;
        q_reg.otp_rd;
    endsequence

    property p_otp_clear;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        s_otp_req |=> !q_reg.otp_rd && (q_reg.otp_data == otp_rom($past(q_reg.otp_addr)));
    endproperty
    a_otp_clear: assert property (p_otp_clear) else $error("trim read not completed");

    property p_temp_single;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        last_conv |=> q_reg.temp_res == $past(temp_code_i);
    endproperty
    a_temp_single: assert property (p_temp_single) else $error("temperature not single");

    property p_fresh_set;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        last_conv |=> q_reg.fresh && q_reg.cnt == 5'h0;
    endproperty
    a_fresh_set: assert property (p_fresh_set) else $error("result not marked valid");

    // a read byte loaded from the data pair while temperature is selected
    sequence s_temp_load(logic [7:0] a);
        q_reg.st != ST_READ && q_next.st == ST_READ && q_reg.sel == SEL_TEMP && q_reg.ptr == a;
    endsequence

    property p_sel_temp;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        s_temp_load(ADDR_DATA_LOW) |=> q_reg.shift == $past(q_reg.temp_res[7:0]);
    endproperty
    a_sel_temp: assert property (p_sel_temp) else $error("temperature not presented");

    property p_temp_high;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        s_temp_load(ADDR_DATA_HIGH) |=> q_reg.shift[6:0] == $past(q_reg.temp_res[14:8]);
    endproperty
    a_temp_high: assert property (p_temp_high) else $error("temperature high byte wrong");

    property p_field_comp;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        last_conv |=> q_reg.field_res == $past(fcomp);
    endproperty
    a_field_comp: assert property (p_field_comp) else $error("field result not updated");

endmodule

// ### core/hstr_pkg.sv
package hstr_pkg;

    // ************************************************************
    // register map (bus addresses)
    // ************************************************************
    localparam logic [7:0] ADDR_DATA_HIGH = 8'hc1;
    localparam logic [7:0] ADDR_DATA_LOW  = 8'hc2;
    localparam logic [7:0] ADDR_SIG_SEL   = 8'hc3;
    localparam logic [7:0] ADDR_BURST     = 8'hc4;
    localparam logic [7:0] ADDR_OTP_ADDR  = 8'he1;
    localparam logic [7:0] ADDR_OTP_DATA  = 8'he2;
    localparam logic [7:0] ADDR_OTP_CTRL  = 8'he3;

    // ************************************************************
    // fields and values
    // ************************************************************
    localparam logic [2:0] SEL_FIELD       = 3'h0;
    localparam logic [2:0] SEL_TEMP        = 3'h1;
    localparam int         SEL_W           = 3;
    localparam logic [2:0] BURST_LOG2_MAX  = 3'h4;
    localparam int         OTP_RD_EN_BIT   = 1;
    localparam int         OTP_BUSY_BIT    = 0;
    localparam int         FRESH_BIT       = 7;
    localparam logic [7:0] OTP_OFFSET_ADDR = 8'h1d;
    localparam logic [7:0] OTP_GAIN_ADDR   = 8'h1e;
    localparam int         CODE_W          = 15;
    localparam int         ACC_W           = 19;
    localparam logic [14:0] CODE_MAX       = 15'h7fff;

    // ************************************************************
    // serial slave states
    // ************************************************************
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_ADDR  = 7'h02,
        ST_ACK_A = 7'h04,
        ST_WRITE = 7'h08,
        ST_ACK_W = 7'h10,
        ST_READ  = 7'h20,
        ST_ACK_R = 7'h40
    } hstr_state_e;

endpackage

// ### bench/hstr_host_model.sv
module hstr_host_model
    import hstr_pkg::*;
(
    input  wire logic sys_clk_i,
    input  wire logic sda_line_i,
    output logic      scl_o,
    output logic      sda_pull_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ************************************************************
    // serial host: open drain, line pulled up when released
    // ************************************************************
    logic [6:0] dev = 7'h30;
    real        off_t = 0.0;
    real        gain_t = 1.0;
    initial
    begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end
    // eight cycles a phase, above the three the synchronisers need
    task automatic half();
        repeat (8) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic start();
        sda_pull_o = 1'b0;
        half();
        scl_o = 1'b1;
        half();
        sda_pull_o = 1'b1;
        half();
        scl_o = 1'b0;
        half();
    endtask
    task automatic stop();
        sda_pull_o = 1'b1;
        half();
        scl_o = 1'b1;
        half();
        sda_pull_o = 1'b0;
        half();
    endtask
    // data moves only while scl is low, sampled as scl rises
    task automatic clk_bit(input logic b, output logic s);
        sda_pull_o = ~b;
        half();
        scl_o = 1'b1;
        s = sda_line_i;
        half();
        scl_o = 1'b0;
        half();
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
        clk_bit(1'b1, s);
        ack = ~s;
    endtask
    task automatic rd_byte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 0; i < 8; i++)
        begin
            clk_bit(1'b1, s);
            d = {d[6:0], s};
        end
        clk_bit(nack, s);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic k1, k2, k3;
        start();
        wr_byte({dev, 1'b0}, k1);
        wr_byte(a, k2);
        wr_byte(d, k3);
        stop();
        ok = k1 & k2 & k3;
    endtask
    // pointer write, repeated start, then bytes high first
    task automatic rd(input logic [7:0] a, input int n, output logic [15:0] q);
        logic k;
        logic [7:0] b;
        start();
        wr_byte({dev, 1'b0}, k);
        wr_byte(a, k);
        start();
        wr_byte({dev, 1'b1}, k);
        q = 16'h0000;
        for (int i = 0; i < n; i++)
        begin
            rd_byte(i == n - 1, b);
            q = {q[7:0], b};
        end
        stop();
    endtask
    task automatic trim(input logic [7:0] ta, output logic [7:0] v);
        logic ok;
        logic [15:0] q;
        wr(ADDR_OTP_ADDR, ta, ok);
        wr(ADDR_OTP_CTRL, 8'h02, ok);
        rd(ADDR_OTP_DATA, 1, q);
        v = q[7:0];
    endtask
    // trims are fetched once and kept, not per reading
    task automatic load_corr();
        logic [7:0] v;
        trim(OTP_OFFSET_ADDR, v);
        off_t = $itor($signed(v)) / 16.0;
        trim(OTP_GAIN_ADDR, v);
        gain_t = 1.0 + $itor($signed(v)) / 2048.0;
    endtask
    // supply unknown here, so the 3.3 v figure stands in
    function automatic real temp_calc(input logic [15:0] p);
        real v;
        v = 32.0 * p[14:8] + (p[7:0] >> 3);
        return gain_t * (-3.83e-6 * v * v + 0.16094 * v - 279.80) + off_t - 0.222 * 3.3;
    endfunction
    // several readings averaged, since one result alone is noisy
    task automatic temp_avg(input int n, output real t);
        logic [15:0] q;
        t = 0.0;
        for (int i = 0; i < n; i++)
        begin
            rd(ADDR_DATA_HIGH, 2, q);
            t = t + temp_calc(q);
        end
        t = t / n;
    endtask
endmodule

// ### bench/tb_top.sv
module tb_top
    import hstr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        sys_clk, rst_b, scl, host_pull, sda_drv, sda_oe_b, conv_done;
    logic [14:0] field_code, temp_code;
    logic [15:0] q;
    logic [7:0]  v;
    logic        ok;
    int          err_count = 0, comparisons = 0, cycles = 0;
    wire         sda_line = !sda_oe_b ? sda_drv : !host_pull;
    initial sys_clk = 1'b0;
    always #5 sys_clk = ~sys_clk;
    hstr_readout #(.TRIM_OFFSET(8'hf0), .TRIM_GAIN(8'h40), .TC_COEF(1)) i_hstr_readout (
        .sys_clk_i(sys_clk), .rst_b_i(rst_b), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_drv), .sda_oe_b_o(sda_oe_b), .conv_done_i(conv_done),
        .field_code_i(field_code), .temp_code_i(temp_code));
    hstr_host_model i_hstr_host_model (
        .sys_clk_i(sys_clk), .sda_line_i(sda_line), .scl_o(scl), .sda_pull_o(host_pull));
    // ************************************************************
    // checking and closing
    // ************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // guards against a hung bus handshake
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            err_count++;
            test_done();
        end
    end
    task automatic pulse(input logic [14:0] f, input logic [14:0] t);
        @(posedge sys_clk);
        #1;
        {conv_done, field_code, temp_code} = {1'b1, f, t};
        @(posedge sys_clk);
        #1;
        {conv_done, field_code, temp_code} = {1'b0, ~f, ~t};
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_temp();
        check(sda_oe_b, 1'b1, "released after reset");
        i_hstr_host_model.rd(ADDR_SIG_SEL, 1, q);
        check(q, 16'h0000, "select reset");
        i_hstr_host_model.wr(ADDR_SIG_SEL, 8'h01, ok);
        check(ok, 1'b1, "select ack");
        i_hstr_host_model.rd(ADDR_SIG_SEL, 1, q);
        check(q, 16'h0001, "select read back");
        pulse(15'h1234, 15'h5abc);
        i_hstr_host_model.rd(ADDR_DATA_HIGH, 2, q);
        check(q, 16'hdabc, "single temperature pair");
        i_hstr_host_model.rd(ADDR_DATA_HIGH, 1, q);
        check(q, 16'h005a, "flag cleared by read");
        $display("test temp done");
    endtask
    task automatic t_burst();
        real t;
        i_hstr_host_model.wr(ADDR_BURST, 8'h02, ok);
        for (int i = 0; i < 3; i++) pulse(15'(100 * (i + 1)), 15'(16'h1000 + i));
        i_hstr_host_model.rd(ADDR_DATA_HIGH, 1, q);
        check(q, 16'h005a, "no result mid burst");
        pulse(15'd400, 15'h2222);
        i_hstr_host_model.rd(ADDR_DATA_HIGH, 2, q);
        check(q, 16'ha222, "burst temperature is last");
        i_hstr_host_model.temp_avg(2, t);
        check(t > -109.36 && t < -109.34, 1'b1, "averaged temperature");
        i_hstr_host_model.wr(ADDR_SIG_SEL, 8'h00, ok);
        i_hstr_host_model.rd(ADDR_DATA_HIGH, 2, q);
        // average 250 plus compensation (8738 - 16384) >>> 8 = -30
        check(q, 16'h00dc, "field averaged and compensated");
        $display("test burst done");
    endtask
    task automatic t_trim();
        real t;
        i_hstr_host_model.trim(OTP_OFFSET_ADDR, v);
        check(v, 8'hf0, "offset trim");
        i_hstr_host_model.rd(ADDR_OTP_CTRL, 1, q);
        check(q[OTP_RD_EN_BIT], 1'b0, "read enable self clears");
        i_hstr_host_model.trim(OTP_GAIN_ADDR, v);
        check(v, 8'h40, "gain trim");
        i_hstr_host_model.load_corr();
        check(i_hstr_host_model.off_t == -1.0, 1'b1, "offset term");
        check(i_hstr_host_model.gain_t == 1.03125, 1'b1, "gain term");
        t = i_hstr_host_model.temp_calc(16'h2222);
        check(t > -113.76 && t < -113.74, 1'b1, "corrected temperature");
        $display("test trim done");
    endtask
    // wrong address, unmapped and read-only places
    task automatic t_refuse();
        i_hstr_host_model.dev = 7'h31;
        i_hstr_host_model.wr(ADDR_SIG_SEL, 8'h01, ok);
        check(ok, 1'b0, "foreign address refused");
        i_hstr_host_model.dev = 7'h30;
        i_hstr_host_model.wr(ADDR_DATA_LOW, 8'h55, ok);
        i_hstr_host_model.rd(ADDR_DATA_LOW, 1, q);
        check(q, 16'h00dc, "read-only low byte kept");
        i_hstr_host_model.rd(8'h50, 1, q);
        check(q, 16'h0000, "unmapped reads zero");
        $display("test refuse done");
    endtask
    initial
    begin
        {rst_b, conv_done, field_code, temp_code} = '0;
        repeat (5) @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        t_temp();
        t_burst();
        t_trim();
        t_refuse();
        test_done();
    end
endmodule
